/* File: hdl/lcsp_cell_pair.sv */
// How it works
// - Both elements share one clock and enable
// - Enable may be tied active per element
// - Each element: edge flip-flop or level latch
// - Flip-flop captures on selected clock edge
// - Clock inversion chosen per element independently
// - Enable active high; low holds both outputs
// - Unconnected enable defaults to active state
// - Flip-flop takes data on active edge only
// - Latch follows data while clock low
// - Local preset/clear forces configured value
// - One bit selects preset or clear value
// - Local preset/clear active high, asynchronous, uninverted
// - Power-up, reconfigure, chip-wide force configured value
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module lcsp_cell_pair (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          cellClock,
  input  wire logic                          cellClockEnable,
  input  wire logic [lcsp_pkg::NUM_ELEM-1:0] cellData,
  input  wire logic                          localPresetClear,
  input  wire logic                          chipWidePresetClear,
  input  wire logic [lcsp_pkg::ADDR_W-1:0]   regAddr,
  input  wire logic [lcsp_pkg::DATA_W-1:0]   regWriteData,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output logic      [lcsp_pkg::DATA_W-1:0]   regReadData,
  output logic      [lcsp_pkg::NUM_ELEM-1:0] cellQ
);

  function automatic logic lcspCfgBit(input logic [lcsp_pkg::DATA_W-1:0] cfg,
                                      input int                          elem,
                                      input int                          field);
    lcspCfgBit = cfg[elem * lcsp_pkg::FLD_STRIDE + field];
  endfunction

  logic                          clockSync;
  logic                          clockPrev;
  logic                          next_clockPrev;
  logic [lcsp_pkg::DATA_W-1:0]   configReg;
  logic [lcsp_pkg::DATA_W-1:0]   next_configReg;
  logic                          reconfigPending;
  logic                          next_reconfigPending;
  logic [lcsp_pkg::DATA_W-1:0]   next_regReadData;
  logic                          cfgWritten;
  logic                          next_cfgWritten;
  logic [lcsp_pkg::NUM_ELEM-1:0] effNow;
  logic [lcsp_pkg::NUM_ELEM-1:0] effPrev;
  logic [lcsp_pkg::NUM_ELEM-1:0] activeEdge;
  logic [lcsp_pkg::NUM_ELEM-1:0] transparent;
  logic [lcsp_pkg::NUM_ELEM-1:0] enableActive;
  logic [lcsp_pkg::NUM_ELEM-1:0] presetValue;
  logic [lcsp_pkg::NUM_ELEM-1:0] isLatch;
  logic                          forceValue;

  //////////////////////////////////////////////////////////////////////////////
  // Cell clock enters from fabric routing, so it is synchronised first

  lcsp_sync u_clock_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (cellClock),
    .syncOut (clockSync)
  );

  always_comb begin
    next_clockPrev = clockSync;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clockPrev <= lcsp_pkg::BIT_LOW;
    end else begin
      clockPrev <= next_clockPrev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  always_comb begin
    next_configReg       = configReg;
    next_reconfigPending = lcsp_pkg::BIT_LOW;
    next_cfgWritten      = cfgWritten;
    next_regReadData     = lcsp_pkg::READ_IDLE;
    if (regWrite && (regAddr == lcsp_pkg::ADDR_CONFIG)) begin
      next_configReg       = regWriteData;
      // Force lands one cycle later, once the new value is in place
      next_reconfigPending = lcsp_pkg::BIT_HIGH;
      next_cfgWritten      = lcsp_pkg::BIT_HIGH;
    end
    if (regRead) begin
      unique case (regAddr)
        lcsp_pkg::ADDR_CONFIG: begin
          next_regReadData = configReg;
        end
        lcsp_pkg::ADDR_STATUS: begin
          next_regReadData = lcsp_pkg::READ_IDLE;
          next_regReadData[lcsp_pkg::STAT_Q_LSB +: lcsp_pkg::NUM_ELEM] = cellQ;
          next_regReadData[lcsp_pkg::STAT_CLK] = clockSync;
        end
        default: begin
          next_regReadData = lcsp_pkg::READ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      configReg       <= lcsp_pkg::CONFIG_RESET;
      reconfigPending <= lcsp_pkg::BIT_LOW;
      cfgWritten      <= lcsp_pkg::BIT_LOW;
      regReadData     <= lcsp_pkg::READ_IDLE;
    end else begin
      configReg       <= next_configReg;
      reconfigPending <= next_reconfigPending;
      cfgWritten      <= next_cfgWritten;
      regReadData     <= next_regReadData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Storage elements

  // No polarity option on the local input; it acts on the next clk edge, without any cell clock edge
  assign forceValue = localPresetClear | chipWidePresetClear | reconfigPending;

  genvar g;
  generate
    for (g = 0; g < lcsp_pkg::NUM_ELEM; g++) begin : gen_elem
      lcsp_pkg::lcsp_mode_t elemMode;

      assign isLatch[g]      = lcspCfgBit(configReg, g, lcsp_pkg::FLD_LATCH);
      assign elemMode        = lcsp_pkg::lcsp_mode_t'(isLatch[g]);
      // Same shared clock, inverted per element
      assign effNow[g]       = clockSync ^ lcspCfgBit(configReg, g, lcsp_pkg::FLD_INVERT);
      assign effPrev[g]      = clockPrev ^ lcspCfgBit(configReg, g, lcsp_pkg::FLD_INVERT);
      assign activeEdge[g]   = effNow[g] & ~effPrev[g];
      assign transparent[g]  = ~effNow[g];
      // Shared enable, no inversion, or tied active
      assign enableActive[g] = cellClockEnable | lcspCfgBit(configReg, g, lcsp_pkg::FLD_TIED);
      assign presetValue[g]  = lcspCfgBit(configReg, g, lcsp_pkg::FLD_INIT);

      lcsp_storage_element u_elem (
        .clk          (clk),
        .rst          (rst),
        .latchMode    (elemMode),
        .activeEdge   (activeEdge[g]),
        .transparent  (transparent[g]),
        .enableActive (enableActive[g]),
        .forceValue   (forceValue),
        .presetValue  (presetValue[g]),
        .dataIn       (cellData[g]),
        .storedQ      (cellQ[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  // Shared clock: with matching setup both capture on the same cycle
  property p_shared_clock;
    (!isLatch[0] && !isLatch[1] && (effNow[0] == effNow[1]) && (&enableActive)
     && !forceValue && activeEdge[0])
    |=> (cellQ == $past(cellData));
  endproperty
  a_shared_clock: assert property (p_shared_clock)
    else $error("elements did not capture together");

  // Shared enable low without tie holds both
  property p_enable_low_holds;
    (!cellClockEnable && !lcspCfgBit(configReg, 0, lcsp_pkg::FLD_TIED)
     && !lcspCfgBit(configReg, 1, lcsp_pkg::FLD_TIED) && !forceValue)
    |=> $stable(cellQ);
  endproperty
  a_enable_low_holds: assert property (p_enable_low_holds)
    else $error("outputs moved while enable low");

  // Enable reset default is active until software writes the setup
  property p_enable_default;
    !cfgWritten |-> (lcspCfgBit(configReg, 0, lcsp_pkg::FLD_TIED)
                     && lcspCfgBit(configReg, 1, lcsp_pkg::FLD_TIED));
  endproperty
  a_enable_default: assert property (p_enable_default)
    else $error("enable default not active");

  // Reconfiguration: write, new setup, then forced value
  sequence s_config_write;
    regWrite && (regAddr == lcsp_pkg::ADDR_CONFIG);
  endsequence

  // Checked on the cycle after the force; a later edge may already move a transparent latch
  sequence s_forced_after;
    ##1 (cellQ[0] == lcspCfgBit(configReg, 0, lcsp_pkg::FLD_INIT))
        && (cellQ[1] == lcspCfgBit(configReg, 1, lcsp_pkg::FLD_INIT));
  endsequence

  property p_reconfig_forces;
    s_config_write ##1 !(regWrite && (regAddr == lcsp_pkg::ADDR_CONFIG)) |-> s_forced_after;
  endproperty
  a_reconfig_forces: assert property (p_reconfig_forces)
    else $error("reconfiguration did not force elements");

  // Chip-wide preset/clear
  property p_chip_wide;
    chipWidePresetClear |=> (cellQ == $past(presetValue));
  endproperty
  a_chip_wide: assert property (p_chip_wide)
    else $error("chip-wide force took wrong value");

  // Any force source beats clock, enable and data on the next edge
  property p_force_wins;
    forceValue |=> (cellQ == $past(presetValue));
  endproperty
  a_force_wins: assert property (p_force_wins)
    else $error("force did not win over data");

  generate
    for (g = 0; g < lcsp_pkg::NUM_ELEM; g++) begin : gen_check
      // Tied enable captures even with shared enable low
      property p_tied_enable;
        (lcspCfgBit(configReg, g, lcsp_pkg::FLD_TIED) && !cellClockEnable && !isLatch[g]
         && !forceValue && activeEdge[g])
        |=> (cellQ[g] == $past(cellData[g]));
      endproperty
      a_tied_enable: assert property (p_tied_enable)
        else $error("tied enable did not capture");

      // Latch mode follows data when transparent
      property p_latch_follow;
        (isLatch[g] && enableActive[g] && transparent[g] && !forceValue)
        |=> (cellQ[g] == $past(cellData[g]));
      endproperty
      a_latch_follow: assert property (p_latch_follow)
        else $error("latch did not follow data");

      // Flip-flop holds when no active edge
      property p_ff_hold;
        (!isLatch[g] && !activeEdge[g] && !forceValue) |=> $stable(cellQ[g]);
      endproperty
      a_ff_hold: assert property (p_ff_hold)
        else $error("flip-flop changed without edge");

      // Inverted clock: raw rising edge is not an active edge
      property p_invert_edge;
        (lcspCfgBit(configReg, g, lcsp_pkg::FLD_INVERT) && clockSync && !clockPrev)
        |-> !activeEdge[g];
      endproperty
      a_invert_edge: assert property (p_invert_edge)
        else $error("inverted element took rising edge");

      // Inverted flip-flop captures on the raw falling edge
      property p_falling_capture;
        (lcspCfgBit(configReg, g, lcsp_pkg::FLD_INVERT) && !isLatch[g] && enableActive[g] && !forceValue
         && !clockSync && clockPrev)
        |=> (cellQ[g] == $past(cellData[g]));
      endproperty
      a_falling_capture: assert property (p_falling_capture)
        else $error("inverted flip-flop missed falling edge");

      // Flip-flop capture on active edge
      property p_ff_capture;
        (!isLatch[g] && enableActive[g] && activeEdge[g] && !forceValue)
        |=> (cellQ[g] == $past(cellData[g]));
      endproperty
      a_ff_capture: assert property (p_ff_capture)
        else $error("flip-flop missed capture");

      // Latch opaque while effective clock high
      property p_latch_hold;
        (isLatch[g] && !transparent[g] && !forceValue) |=> $stable(cellQ[g]);
      endproperty
      a_latch_hold: assert property (p_latch_hold)
        else $error("latch changed while opaque");

      // Latch with enable low holds even while transparent
      property p_latch_enable_low;
        (isLatch[g] && !enableActive[g] && !forceValue) |=> $stable(cellQ[g]);
      endproperty
      a_latch_enable_low: assert property (p_latch_enable_low)
        else $error("latch moved with enable low");

      // Local force held two cycles keeps the value regardless of data
      sequence s_local_held;
        localPresetClear [*2];
      endsequence

      property p_local_force;
        s_local_held |-> (cellQ[g] == $past(presetValue[g]));
      endproperty
      a_local_force: assert property (p_local_force)
        else $error("local force not applied");

      // Local force acts with the cell clock standing still
      property p_local_async;
        (localPresetClear && (clockSync == clockPrev)) |=> (cellQ[g] == $past(presetValue[g]));
      endproperty
      a_local_async: assert property (p_local_async)
        else $error("local force needed a clock edge");
    end
  endgenerate

endmodule

/* File: hdl/lcsp_pkg.sv */
package lcsp_pkg;

  localparam int NUM_ELEM = 2;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

  // Configuration fields, one nibble per element
  localparam int FLD_LATCH  = 0;
  localparam int FLD_INVERT = 1;
  localparam int FLD_TIED   = 2;
  localparam int FLD_INIT   = 3;
  localparam int FLD_STRIDE = 4;

  // Both enables tied active, flip-flop mode, rising edge, clear value
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h44;

  // Status fields
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_CLK   = 2;

  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
  localparam logic              BIT_LOW   = 1'h0;
  localparam logic              BIT_HIGH  = 1'h1;

  typedef enum logic {
    LCSP_MODE_FLIP_FLOP = 1'h0,
    LCSP_MODE_LATCH     = 1'h1
  } lcsp_mode_t;

endpackage

/* File: hdl/lcsp_sync.sv */
`timescale 1ns/100ps
module lcsp_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;
  logic next_stage1;
  logic next_syncOut;

  // First stage feeds the second stage only
  always_comb begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1  <= lcsp_pkg::BIT_LOW;
      syncOut <= lcsp_pkg::BIT_LOW;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

/* File: hdl/lcsp_storage_element.sv */
`timescale 1ns/100ps
module lcsp_storage_element (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  lcsp_pkg::lcsp_mode_t      latchMode,
  input  wire logic                 activeEdge,
  input  wire logic                 transparent,
  input  wire logic                 enableActive,
  input  wire logic                 forceValue,
  input  wire logic                 presetValue,
  input  wire logic                 dataIn,
  output logic                      storedQ
);

  logic next_storedQ;

  always_comb begin
    next_storedQ = storedQ;
    if (forceValue) begin
      // Preset or clear overrides clock, enable and data
      next_storedQ = presetValue;
    end else if (enableActive) begin
      unique case (latchMode)
        lcsp_pkg::LCSP_MODE_LATCH: begin
          if (transparent) begin
            next_storedQ = dataIn;
          end
        end
        lcsp_pkg::LCSP_MODE_FLIP_FLOP: begin
          if (activeEdge) begin
            next_storedQ = dataIn;
          end
        end
      endcase
    end
  end

  // Power-up value is clear, which matches the reset configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      storedQ <= lcsp_pkg::BIT_LOW;
    end else begin
      storedQ <= next_storedQ;
    end
  end

endmodule

/* File: bench/lcsp_fabric_model.sv */
`timescale 1ns/100ps
module lcsp_fabric_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       reqClock,
  input  wire logic       reqEnable,
  input  wire logic [1:0] reqData,
  input  wire logic       reqLocal,
  input  wire logic       reqChip,
  output logic            cellClock,
  output logic            cellClockEnable,
  output logic      [1:0] cellData,
  output logic            localPresetClear,
  output logic            chipWidePresetClear
);
  ////////////////////////////////////////////////////////////////
  // Fabric logic registers its outputs, so every pin moves just after a clk edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cellClock           <= 1'h0;
      cellClockEnable     <= 1'h0;
      cellData            <= 2'h0;
      localPresetClear    <= 1'h0;
      chipWidePresetClear <= 1'h0;
    end else begin
      cellClock           <= reqClock;
      cellClockEnable     <= reqEnable;
      cellData            <= reqData;
      localPresetClear    <= reqLocal;
      chipWidePresetClear <= reqChip;
    end
  end
endmodule

/* File: bench/lcsp_cell_pair_test.sv */
`timescale 1ns/100ps
module lcsp_cell_pair_test;
  // Ceiling well above the roughly 3400 cycles the sequence needs
  localparam int LIMIT = 20000;
  logic       clk, rst, reqClock, reqEnable, reqLocal, reqChip;
  logic [1:0] reqData;
  logic       cellClock, cellClockEnable, localPresetClear, chipWidePresetClear;
  logic [1:0] cellData, cellQ, qExp, curD;
  logic [3:0] regAddr;
  logic [7:0] regWriteData, regReadData, cfg, rd;
  logic       regWrite, regRead, curK, curEn, curLp, curGs;
  int         checks, failCount, cycles;
  int unsigned seedVal;

  lcsp_fabric_model lcsp_fabric_model_inst (.clk(clk), .rst(rst), .reqClock(reqClock), .reqEnable(reqEnable),
    .reqData(reqData), .reqLocal(reqLocal), .reqChip(reqChip), .cellClock(cellClock),
    .cellClockEnable(cellClockEnable), .cellData(cellData), .localPresetClear(localPresetClear),
    .chipWidePresetClear(chipWidePresetClear));
  lcsp_cell_pair lcsp_cell_pair_inst (.clk(clk), .rst(rst), .cellClock(cellClock),
    .cellClockEnable(cellClockEnable), .cellData(cellData), .localPresetClear(localPresetClear),
    .chipWidePresetClear(chipWidePresetClear), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .cellQ(cellQ));

  ////////////////////////////////////////////////////////////////
  // Data is not synchronised but the clock is, so new data is seen before a clock change
  function automatic logic elemNext(input logic [3:0] f, input logic q, input logic kOld, input logic kNew,
                                    input logic en, input logic d, input logic frc);
    logic r;
    logic eOld;
    logic eNew;
    r = q;
    eOld = kOld ^ f[1];
    eNew = kNew ^ f[1];
    if (frc) r = f[3];
    else if (f[0] && (en || f[2]) && (!eOld || !eNew)) r = d;
    else if (!f[0] && (en || f[2]) && !eOld && eNew) r = d;
    return r;
  endfunction

  function automatic logic rb(input int n);
    return $urandom_range(n) == 0;
  endfunction

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check2(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'h1;
    @(posedge clk);
    regWrite <= 1'h0;
  endtask

  task automatic regRd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clk);
    regRead <= 1'h0;
    #1 d = regReadData;
  endtask

  task automatic apply(input logic k, input logic en, input logic [1:0] d, input logic lp, input logic gs);
    logic [7:0] st;
    @(posedge clk);
    reqClock <= k;
    reqEnable <= en;
    reqData <= d;
    reqLocal <= lp;
    reqChip <= gs;
    for (int i = 0; i < 2; i++) qExp[i] = elemNext(cfg[4*i +: 4], qExp[i], curK, k, en, d[i], lp | gs);
    curK = k;
    curEn = en;
    curD = d;
    curLp = lp;
    curGs = gs;
    // Six cycles cover fabric register, two-flop sync and the capture
    repeat (6) @(posedge clk);
    #1 check2("cellQ", qExp, cellQ);
    regRd(lcsp_pkg::ADDR_STATUS, st);
    check8("status", {5'h00, k, qExp}, st);
  endtask

  task automatic cfgWr(input logic [7:0] v);
    regWr(lcsp_pkg::ADDR_CONFIG, v);
    cfg = v;
    qExp = {v[7], v[3]};
    regRd(lcsp_pkg::ADDR_CONFIG, rd);
    check8("config", v, rd);
    apply(curK, curEn, curD, curLp, curGs);
  endtask

  task automatic giveVerdict();
    $display("Comparisons made: %0d, mismatches: %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failCount++;
      giveVerdict();
    end
  end

  initial begin
    {rst, regWrite, regRead, curK, curEn, curLp, curGs} = 7'h40;
    {reqClock, reqEnable, reqLocal, reqChip, reqData, curD, qExp} = 10'h000;
    {regAddr, regWriteData} = 12'h000;
    checks = 0;
    failCount = 0;
    cycles = 0;
    cfg = lcsp_pkg::CONFIG_RESET;
    seedVal = $urandom(53);
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    regRd(lcsp_pkg::ADDR_CONFIG, rd);
    check8("config reset", lcsp_pkg::CONFIG_RESET, rd);
    check2("cellQ reset", 2'h0, cellQ);
    apply(1'h0, 1'h0, 2'h2, 1'h0, 1'h0);
    apply(1'h1, 1'h0, 2'h3, 1'h0, 1'h0);
    apply(1'h0, 1'h0, 2'h0, 1'h0, 1'h0);
    cfgWr(8'h00);
    apply(1'h1, 1'h0, 2'h3, 1'h0, 1'h0);
    apply(1'h0, 1'h1, 2'h3, 1'h0, 1'h0);
    apply(1'h1, 1'h1, 2'h3, 1'h0, 1'h0);
    apply(1'h1, 1'h1, 2'h0, 1'h0, 1'h0);
    // Inversion changed while the clock is high, so neither element sees a rise
    cfgWr(8'h20);
    apply(1'h0, 1'h1, 2'h3, 1'h0, 1'h0);
    apply(1'h1, 1'h1, 2'h0, 1'h0, 1'h0);
    cfgWr(8'h91);
    apply(1'h1, 1'h1, 2'h1, 1'h0, 1'h0);
    apply(1'h0, 1'h1, 2'h1, 1'h0, 1'h0);
    apply(1'h0, 1'h1, 2'h2, 1'h0, 1'h0);
    apply(1'h0, 1'h1, 2'h1, 1'h1, 1'h0);
    apply(1'h0, 1'h1, 2'h1, 1'h0, 1'h0);
    apply(1'h1, 1'h1, 2'h1, 1'h0, 1'h1);
    cfgWr(8'h88);
    apply(1'h1, 1'h1, 2'h0, 1'h1, 1'h0);
    regRd(4'h8, rd);
    check8("unmapped read", lcsp_pkg::READ_IDLE, rd);
    regWr(4'hC, 8'hFF);
    regWr(lcsp_pkg::ADDR_STATUS, 8'hFF);
    regRd(lcsp_pkg::ADDR_CONFIG, rd);
    check8("config after ignored writes", cfg, rd);
    apply(curK, curEn, curD, curLp, curGs);
    // Random writes keep the inversion bits so a write never fakes a clock edge
    for (int n = 0; n < 300; n++) begin
      if (rb(7)) cfgWr((8'($urandom()) & 8'hDD) | (cfg & 8'h22));
      apply(rb(1), rb(1), 2'($urandom_range(3)), rb(7), rb(9));
    end
    giveVerdict();
  end
endmodule
